// ==== gate_interlock_pkg.sv ====
package gate_interlock_pkg;

    // ****************************************************************
    // Register map (byte addresses on the APB)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_DIAG_TX = 8'h14;
    localparam logic [7:0] ADDR_DIAG_RX = 8'h18;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_DIAG_ALLOW = 0;
    localparam int ST_SAFETY_OUT = 0;
    localparam int ST_ACTUATOR = 1;
    localparam int ST_LOCKED = 2;
    localparam int ST_SERIES_A = 3;
    localparam int ST_SERIES_B = 4;
    localparam int ST_UNEQUAL = 5;
    localparam int ST_PLAUS_ERR = 6;
    localparam int ST_ATTACHED = 7;
    localparam int ST_LOCK_REQ_A = 8;
    localparam int ST_LOCK_REQ_B = 9;
    localparam int ST_TX_BUSY = 10;
    localparam int IRQ_WIDTH = 5;
    localparam int IRQ_OUT_DROP = 0;
    localparam int IRQ_UNEQUAL = 1;
    localparam int IRQ_PLAUS_ERR = 2;
    localparam int IRQ_RX_BYTE = 3;
    localparam int IRQ_TX_DONE = 4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic CTRL_RESET = 1'h1;
    localparam logic [IRQ_WIDTH-1:0] IRQ_ENABLE_RESET = 5'h00;
    // Pin order: diag_in, lock_req_b, lock_req_a, locked, actuator, series_b, series_a
    localparam int PIN_COUNT = 7;
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 7'h40;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);
    localparam int DIAG_BIT_US = 100;
    localparam int DIAG_BIT_CYCLES = DIAG_BIT_US * (CLK_HZ / 1_000_000);
    localparam int DIAG_FRAME_BITS = 10;

    typedef enum logic [1:0] {PL_NORMAL, PL_UNEQUAL, PL_LOCKOUT} plaus_state_t;

endpackage

// ==== gate_plaus_if.sv ====
`timescale 1ns/1ps
// Synchronised series inputs out, plausibility verdict back
interface gate_plaus_if;
    logic series_a;
    logic series_b;
    logic unequal;
    logic plaus_error;
    logic inputs_ok;
    modport owner (output series_a, output series_b, input unequal, input plaus_error, input inputs_ok);
    modport monitor (input series_a, input series_b, output unequal, output plaus_error, output inputs_ok);
endinterface

// ==== gate_plausibility_monitor.sv ====
`timescale 1ns/1ps
module gate_plausibility_monitor
    import gate_interlock_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    gate_plaus_if.monitor plaus
);
    plaus_state_t state;
    plaus_state_t next_state;
    logic both_high;
    logic both_low;
    logic prev_both_high;

    assign both_high = plaus.series_a && plaus.series_b;
    assign both_low = !plaus.series_a && !plaus.series_b;

    // ****************************************************************
    // Plausibility state
    // ****************************************************************
    // One input dropping alone marks the pair unequal
    always_comb
    begin
        next_state = state;
        unique case (state)
            PL_NORMAL:
                if (prev_both_high && (plaus.series_a ^ plaus.series_b))
                    next_state = PL_UNEQUAL;
            PL_UNEQUAL:
                if (both_low)
                    next_state = PL_NORMAL;
                else if (both_high)
                    next_state = PL_LOCKOUT;
            PL_LOCKOUT:
                if (both_low)
                    next_state = PL_NORMAL;
        endcase
    end

    // State and previous-pair history
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state <= PL_NORMAL;
            prev_both_high <= 1'h0;
        end
        else
        begin
            state <= next_state;
            prev_both_high <= both_high;
        end
    end

    // Yellow flash covers both unequal and lockout
    assign plaus.unequal = (state != PL_NORMAL);
    assign plaus.plaus_error = (state == PL_LOCKOUT);
    assign plaus.inputs_ok = (state == PL_NORMAL) && both_high;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_unequal_entry: assert property (prev_both_high && state == PL_NORMAL && (plaus.series_a ^ plaus.series_b)
        |=> plaus.unequal && !plaus.plaus_error) else $error("unequal pair not flagged");
    a_lockout_entry: assert property (state == PL_UNEQUAL && both_high
        |=> plaus.plaus_error ##0 !plaus.inputs_ok) else $error("lockout not entered");
    a_release_low: assert property ($fell(plaus.unequal) |-> $past(both_low))
        else $error("lock released without both low");
endmodule // gate_plausibility_monitor

// ==== gate_interlock_output_logic.sv ====
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
// Operation
// - Both safety outputs are high only while actuator is detected, locking pin is locked and both series inputs are high.
// - Both safety outputs go low as soon as any one of those enabling conditions is missing.
// - One series input falling while the other stays high flags an unequal status, shown by a yellow flashing input lamp.
// - The fallen input rising again while the other stayed high raises a plausibility error and a partial lockout.
// - After an unequal status, normal operation returns only after both series inputs have been seen low together.
// - An attached diagnostic fieldbus module makes the device activate its diagnostic input and read data from it.
// - The combined signal/diagnostic output presents the actuator-detected status.
// - With a fieldbus module attached, the combined output carries written diagnostic data instead.
// - The safety outputs depend on actuator position and on the locking pin driven by the lock requests.
module gate_interlock_output_logic
    import gate_interlock_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_HALF_CYCLES,
    parameter int BIT_CYCLES = DIAG_BIT_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic series_in_a,
    input wire logic series_in_b,
    input wire logic lock_request_a,
    input wire logic lock_request_b,
    input wire logic actuator_detected,
    input wire logic lock_confirmed,
    input wire logic diag_in,
    output logic diag_signal_out,
    output logic safety_out_a,
    output logic safety_out_b,
    output logic input_led_yellow
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (FLASH_CYCLES < 2)
        $error("FLASH_CYCLES must be at least 2");
    if (BIT_CYCLES < 4)
        $error("BIT_CYCLES must be at least 4");

    gate_plaus_if plaus ();

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic act_s;
    logic lock_s;
    logic req_a_s;
    logic req_b_s;
    logic diag_s;
    logic diag_prev;
    logic out_enable;
    logic ctrl_diag_allow;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_enable;
    logic [IRQ_WIDTH-1:0] irq_event;
    logic [IRQ_WIDTH-1:0] irq_clear;
    logic prev_unequal;
    logic prev_plaus_error;
    logic fieldbus_attached;
    logic [31:0] flash_cnt;
    logic flash_phase;
    logic rx_busy;
    logic [31:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_done;
    logic tx_busy;
    logic [31:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_frame;
    logic tx_done;
    logic tx_start;
    logic apb_write;
    logic apb_setup;

    // Word decode shared by read and write paths
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_CLEAR)
            || (a == ADDR_IRQ_ENABLE) || (a == ADDR_DIAG_TX) || (a == ADDR_DIAG_RX);
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    assign pin_raw = {diag_in, lock_request_b, lock_request_a, lock_confirmed, actuator_detected,
        series_in_b, series_in_a};

    // Two flops per pin; the first stage feeds only the second
    genvar gi;
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
        always_ff @(posedge ref_clk)
        begin
            if (sys_rst)
            begin
                pin_meta[gi] <= PIN_RESET[gi];
                pin_sync[gi] <= PIN_RESET[gi];
            end
            else
            begin
                pin_meta[gi] <= pin_raw[gi];
                pin_sync[gi] <= pin_meta[gi];
            end
        end
    end

    assign plaus.series_a = pin_sync[0];
    assign plaus.series_b = pin_sync[1];
    assign act_s = pin_sync[2];
    assign lock_s = pin_sync[3];
    assign req_a_s = pin_sync[4];
    assign req_b_s = pin_sync[5];
    assign diag_s = pin_sync[6];

    gate_plausibility_monitor u_plaus (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .plaus (plaus.monitor)
    );

    // ****************************************************************
    // Safety outputs
    // ****************************************************************
    // Locked pin is the only path by which lock requests reach the outputs
    assign out_enable = act_s && lock_s && plaus.inputs_ok;

    // Registered so both channels switch on the same edge
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            safety_out_a <= 1'h0;
            safety_out_b <= 1'h0;
        end
        else
        begin
            safety_out_a <= out_enable;
            safety_out_b <= out_enable;
        end
    end

    // ****************************************************************
    // Input indicator flash
    // ****************************************************************
    // Free-running blink so the lamp phase is independent of the fault time
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            flash_cnt <= 32'h0;
            flash_phase <= 1'h0;
        end
        else if (flash_cnt == 32'(FLASH_CYCLES - 1))
        begin
            flash_cnt <= 32'h0;
            flash_phase <= !flash_phase;
        end
        else
            flash_cnt <= flash_cnt + 32'h1;
    end

    // Lamp lit during the on phase while unequal or locked out
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            input_led_yellow <= 1'h0;
        else
            input_led_yellow <= plaus.unequal && flash_phase;
    end

    // ****************************************************************
    // Diagnostic input: attach detection and receiver
    // ****************************************************************
    // Idle line is high; the first start bit marks an attached module until reset
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            fieldbus_attached <= 1'h0;
            diag_prev <= 1'h1;
        end
        else
        begin
            diag_prev <= diag_s;
            if (ctrl_diag_allow && diag_prev && !diag_s)
                fieldbus_attached <= 1'h1;
        end
    end

    // Start, eight data bits LSB first, stop; sampled mid-bit
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rx_busy <= 1'h0;
            rx_cnt <= 32'h0;
            rx_bit <= 4'h0;
            rx_shift <= 8'h00;
            rx_data <= 8'h00;
            rx_done <= 1'h0;
        end
        else
        begin
            rx_done <= 1'h0;
            if (!rx_busy)
            begin
                if (ctrl_diag_allow && diag_prev && !diag_s)
                begin
                    rx_busy <= 1'h1;
                    rx_cnt <= 32'(BIT_CYCLES / 2);
                    rx_bit <= 4'h0;
                end
            end
            else if (rx_cnt == 32'(BIT_CYCLES - 1))
            begin
                rx_cnt <= 32'h0;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'(DIAG_FRAME_BITS - 1))
                begin
                    rx_busy <= 1'h0;
                    rx_data <= rx_shift;
                    rx_done <= 1'h1;
                end
                else if (rx_bit != 4'h0)
                    rx_shift <= {diag_s, rx_shift[7:1]};
            end
            else
                rx_cnt <= rx_cnt + 32'h1;
        end
    end

    // ****************************************************************
    // Signal/diagnostic output
    // ****************************************************************
    assign tx_start = apb_write && (paddr == ADDR_DIAG_TX) && fieldbus_attached && !tx_busy;

    // Writes while unattached or busy are dropped; the line keeps its meaning
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tx_busy <= 1'h0;
            tx_cnt <= 32'h0;
            tx_bit <= 4'h0;
            tx_frame <= 10'h3FF;
            tx_done <= 1'h0;
        end
        else
        begin
            tx_done <= 1'h0;
            if (tx_start)
            begin
                tx_busy <= 1'h1;
                tx_cnt <= 32'h0;
                tx_bit <= 4'h0;
                tx_frame <= {1'h1, pwdata[7:0], 1'h0};
            end
            else if (tx_busy)
            begin
                if (tx_cnt == 32'(BIT_CYCLES - 1))
                begin
                    tx_cnt <= 32'h0;
                    tx_frame <= {1'h1, tx_frame[9:1]};
                    tx_bit <= tx_bit + 4'h1;
                    if (tx_bit == 4'(DIAG_FRAME_BITS - 1))
                    begin
                        tx_busy <= 1'h0;
                        tx_done <= 1'h1;
                    end
                end
                else
                    tx_cnt <= tx_cnt + 32'h1;
            end
        end
    end

    // Actuator status until a module attaches, then frame data
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            diag_signal_out <= 1'h0;
        else if (fieldbus_attached)
            diag_signal_out <= tx_start ? 1'h0 : (tx_busy ? tx_frame[0] : 1'h1);
        else
            diag_signal_out <= act_s;
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign irq_event[IRQ_OUT_DROP] = safety_out_a && !out_enable;
    assign irq_event[IRQ_UNEQUAL] = plaus.unequal && !prev_unequal;
    assign irq_event[IRQ_PLAUS_ERR] = plaus.plaus_error && !prev_plaus_error;
    assign irq_event[IRQ_RX_BYTE] = rx_done;
    assign irq_event[IRQ_TX_DONE] = tx_done;
    assign irq_clear = (apb_write && paddr == ADDR_IRQ_CLEAR) ? pwdata[IRQ_WIDTH-1:0] : '0;

    // Sticky bits: an event in the clearing cycle survives
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            irq_status <= '0;
            prev_unequal <= 1'h0;
            prev_plaus_error <= 1'h0;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            prev_unequal <= plaus.unequal;
            prev_plaus_error <= plaus.plaus_error;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign pready = 1'h1;
    assign pslverr = psel && penable && !addr_mapped(paddr);

    // Writable registers update only at the access edge
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctrl_diag_allow <= CTRL_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
        end
        else if (apb_write && paddr == ADDR_CTRL)
            ctrl_diag_allow <= pwdata[CTRL_DIAG_ALLOW];
        else if (apb_write && paddr == ADDR_IRQ_ENABLE)
            irq_enable <= pwdata[IRQ_WIDTH-1:0];
    end

    // Read data captured in the setup cycle, so it is a flop at access
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            prdata <= 32'h0;
        else if (apb_setup && !pwrite)
        begin
            prdata <= 32'h0;
            unique case (paddr)
                ADDR_CTRL: prdata[CTRL_DIAG_ALLOW] <= ctrl_diag_allow;
                ADDR_STATUS:
                begin
                    prdata[ST_SAFETY_OUT] <= safety_out_a;
                    prdata[ST_ACTUATOR] <= act_s;
                    prdata[ST_LOCKED] <= lock_s;
                    prdata[ST_SERIES_A] <= plaus.series_a;
                    prdata[ST_SERIES_B] <= plaus.series_b;
                    prdata[ST_UNEQUAL] <= plaus.unequal;
                    prdata[ST_PLAUS_ERR] <= plaus.plaus_error;
                    prdata[ST_ATTACHED] <= fieldbus_attached;
                    prdata[ST_LOCK_REQ_A] <= req_a_s;
                    prdata[ST_LOCK_REQ_B] <= req_b_s;
                    prdata[ST_TX_BUSY] <= tx_busy;
                end
                ADDR_IRQ_STATUS: prdata[IRQ_WIDTH-1:0] <= irq_status;
                ADDR_IRQ_ENABLE: prdata[IRQ_WIDTH-1:0] <= irq_enable;
                ADDR_DIAG_RX: prdata[7:0] <= rx_data;
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_out_enable_cond: assert property (act_s && lock_s && plaus.inputs_ok |=> safety_out_a && safety_out_b)
        else $error("outputs not enabled");
    a_out_drop_next: assert property (!(act_s && lock_s && plaus.inputs_ok) |=> !safety_out_a && !safety_out_b)
        else $error("outputs not dropped");
    a_out_needs_lock: assert property ($fell(lock_s) |=> !safety_out_a && !safety_out_b)
        else $error("outputs high with pin unlocked");
    a_series_sync_path: assert property ($rose(safety_out_a) |-> $past(pin_meta[0], 2) && $past(pin_meta[1], 2))
        else $error("outputs enabled before series sync");
    a_flash_follows: assert property (!plaus.unequal |=> !input_led_yellow)
        else $error("lamp lit without unequal status");
    a_flash_lockout: assert property (plaus.plaus_error && flash_phase |=> input_led_yellow)
        else $error("lamp dark during lockout");
    a_diag_attach: assert property (ctrl_diag_allow && diag_prev && !diag_s |=> fieldbus_attached && rx_busy)
        else $error("diagnostic input not activated");
    a_actuator_echo: assert property (!fieldbus_attached |=> diag_signal_out == $past(act_s))
        else $error("signal output not actuator status");
    a_tx_start_bit: assert property (tx_start |=> !diag_signal_out && tx_busy)
        else $error("diagnostic frame not started");

    c_outputs_on: cover property ($rose(safety_out_a));
    c_lockout: cover property ($rose(plaus.plaus_error));
    c_rx_byte: cover property (rx_done);
    c_tx_done: cover property (tx_done);
endmodule // gate_interlock_output_logic

// ==== gate_fieldbus_model.sv ====
`timescale 1ns/1ps
// Diagnostic fieldbus stand-in: frames one byte onto the diagnostic line on request
module gate_fieldbus_model
#(
    parameter int BIT_CYCLES = 8
)
(
    input wire logic ref_clk,
    input wire logic send,
    input wire logic [7:0] data,
    output logic diag_in
);
    logic [9:0] frame;
    int i;
    // Idle high, as an unused diagnostic input must be held high
    initial diag_in = 1'b1;
    // Data is taken on the clock edge, not on send, to avoid racing its update
    always @(posedge ref_clk)
    begin
        if (send === 1'b1)
        begin
            frame = {1'b1, data, 1'b0};
            for (i = 0; i < 10; i++)
            begin
                diag_in <= frame[i];
                repeat (BIT_CYCLES) @(posedge ref_clk);
            end
        end
    end
endmodule // gate_fieldbus_model

// ==== gate_interlock_output_logic_tb.sv ====
`timescale 1ns/1ps
module gate_interlock_output_logic_tb;
    import gate_interlock_pkg::*;
    localparam int FC = 4;
    localparam int BC = 8;
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, fb_data = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, x;
    logic pready, pslverr, irq, e, diag_in, diag_signal_out, so_a, so_b, led, fb_send = 1'b0;
    logic series_in_a = 1'b0, series_in_b = 1'b0, lock_request_a = 1'b0, lock_request_b = 1'b0;
    logic actuator_detected = 1'b0, lock_confirmed = 1'b0;
    logic [9:0] fr;
    int error_cnt = 0, checks_done = 0, n, i;

    // ****************************************************************
    // Bench infrastructure
    // ****************************************************************
    always #10 ref_clk = ~ref_clk;

    gate_interlock_output_logic #(.FLASH_CYCLES(FC), .BIT_CYCLES(BC)) u_dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .series_in_a(series_in_a),
        .series_in_b(series_in_b), .lock_request_a(lock_request_a), .lock_request_b(lock_request_b),
        .actuator_detected(actuator_detected), .lock_confirmed(lock_confirmed), .diag_in(diag_in),
        .diag_signal_out(diag_signal_out), .safety_out_a(so_a), .safety_out_b(so_b),
        .input_led_yellow(led));

    // Fieldbus output feeds our diagnostic input, as in a chain
    gate_fieldbus_model #(.BIT_CYCLES(BC)) u_bus (.ref_clk(ref_clk), .send(fb_send), .data(fb_data),
        .diag_in(diag_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Outputs enabled only when series pair, actuator and lock all hold
    function automatic logic exp_out(input logic [31:0] v);
        return v[2] & v[1] & v[0];
    endfunction

    // Expected status bits 10:0 for a gate state drawn from v
    function automatic logic [10:0] exp_status(input logic [31:0] v);
        return {1'b0, v[5:4], 3'b000, v[2], v[2], v[1], v[0], exp_out(v)};
    endfunction

    // One APB transfer; waits on pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic er);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // Pins take three edges to reach the outputs, so four are allowed
    task automatic pins(input logic [3:0] v);
        @(posedge ref_clk);
        {series_in_a, series_in_b, actuator_detected, lock_confirmed} <= v;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic led_seen();
        n = 0;
        repeat (3 * FC)
        begin
            @(posedge ref_clk);
            if (led === 1'b1) n++;
        end
        chk(n != 0, 1'b1);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        #400_000;
        error_cnt++;
        report_and_stop();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        x = $urandom(59);
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h1F, r, e);
        // Random gate states; series inputs move together to stay plausible
        repeat (40)
        begin
            x = $urandom;
            {lock_request_b, lock_request_a} <= x[5:4];
            pins({x[2], x[2], x[0], x[1]});
            chk({so_a, so_b}, {2{exp_out(x)}});
            chk(diag_signal_out, x[0]);
            apb(1'b0, ADDR_STATUS, 32'h0, r, e);
            chk(r[10:0], exp_status(x));
        end
        // One input drops, returns, then both low restores operation
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1F, r, e);
        pins(4'hF);
        chk({so_a, so_b}, 2'b11);
        pins(4'h7);
        chk({so_a, so_b}, 2'b00);
        apb(1'b0, ADDR_STATUS, 32'h0, r, e);
        chk(r[6:5], 2'b01);
        led_seen();
        pins(4'hF);
        chk({so_a, so_b}, 2'b00);
        apb(1'b0, ADDR_STATUS, 32'h0, r, e);
        chk(r[6], 1'b1);
        led_seen();
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0, r, e);
        chk(r[4:0], 5'h07);
        chk(irq, 1'b1);
        pins(4'h3);
        pins(4'hF);
        chk({so_a, so_b}, 2'b11);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1F, r, e);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0, r, e);
        chk({irq, r[4:0]}, 6'h00);
        // Unmapped address is refused with zero data
        apb(1'b0, 8'h3C, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        // Diagnostic input can be switched off and back on
        apb(1'b1, ADDR_CTRL, 32'h0, r, e);
        apb(1'b0, ADDR_CTRL, 32'h0, r, e);
        chk(r[0], 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1, r, e);
        // Fieldbus attaches by sending a byte
        x = $urandom;
        fb_data <= x[7:0];
        fb_send <= 1'b1;
        @(posedge ref_clk);
        fb_send <= 1'b0;
        repeat (11 * BC + 6) @(posedge ref_clk);
        apb(1'b0, ADDR_DIAG_RX, 32'h0, r, e);
        chk(r[7:0], x[7:0]);
        apb(1'b0, ADDR_STATUS, 32'h0, r, e);
        chk(r[7], 1'b1);
        // Once attached the combined output carries our frame
        x = $urandom;
        apb(1'b1, ADDR_DIAG_TX, {24'h0, x[7:0]}, r, e);
        n = 0;
        while (diag_signal_out !== 1'b0 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        repeat (BC / 2) @(posedge ref_clk);
        for (i = 0; i < 10; i++)
        begin
            fr[i] = diag_signal_out;
            repeat (BC) @(posedge ref_clk);
        end
        chk(fr, {1'b1, x[7:0], 1'b0});
        report_and_stop();
    end
endmodule // gate_interlock_output_logic_tb
